// ===== rtl/bcw_pkg.sv
// Package: register map, field layout, reset values and timing of the boot clock block
package bcw_pkg;

	// ************************************************************
	// Clock rates and timing counts
	// ************************************************************
	localparam int unsigned CLK_HZ        = 50_000_000;
	localparam int unsigned SLOW_HZ       = 32_768;
	localparam int unsigned SLOW_DIV_CYC  = CLK_HZ / SLOW_HZ;
	localparam int unsigned OSC_UNIT_SLOW = 8;
	localparam int unsigned MCK_SW_SLOW   = 2;

	// ************************************************************
	// Register byte offsets
	// ************************************************************
	localparam logic [7:0] OFS_MOR   = 8'h00;
	localparam logic [7:0] OFS_PLL   = 8'h04;
	localparam logic [7:0] OFS_MCK   = 8'h08;
	localparam logic [7:0] OFS_STAT  = 8'h0C;
	localparam logic [7:0] OFS_ISTS  = 8'h10;
	localparam logic [7:0] OFS_IMSK  = 8'h14;
	localparam logic [7:0] OFS_WATCHDOG_MODE_REGISTER  = 8'h18;
	localparam logic [7:0] OFS_RATIO = 8'h1C;

	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int unsigned MOR_EN_BIT   = 0;
	localparam int unsigned MOR_CNT_LSB  = 8;
	localparam int unsigned PLL_DIV_LSB  = 0;
	localparam int unsigned PLL_CNT_LSB  = 8;
	localparam int unsigned PLL_MUL_LSB  = 16;
	localparam int unsigned MCK_CSS_LSB  = 0;
	localparam int unsigned MCK_PRESCALER_FIELD_LSB = 2;
	localparam int unsigned MCK_MASTER_DIVIDER_FIELD_LSB = 8;
	localparam int unsigned STS_OSC_BIT  = 0;
	localparam int unsigned STS_LOCK_BIT = 1;
	localparam int unsigned STS_MCK_BIT  = 3;
	localparam int unsigned WD_DIS_BIT   = 15;
	localparam int unsigned RATIO_MUL_LSB = 16;

	// Clock source codes
	localparam logic [1:0] CSS_SLOW = 2'h0;
	localparam logic [1:0] CSS_MAIN = 2'h1;
	localparam logic [1:0] CSS_PLL  = 2'h2;

	// ************************************************************
	// Carriers
	// ************************************************************
	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [7:0]  adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} bcw_wb_req_s;

	typedef struct packed {
		logic        ack;
		logic [31:0] dat;
	} bcw_wb_rsp_s;

	typedef struct packed {
		logic        ack;
		logic [31:0] dat;
		logic [10:0] slow_div;
		logic        slow_tick;
		logic        osc_en;
		logic [7:0]  osc_cnt;
		logic [10:0] osc_timer;
		logic        osc_stable;
		logic [7:0]  pll_div;
		logic [5:0]  pll_cnt;
		logic [10:0] pll_mul;
		logic [5:0]  pll_timer;
		logic        pll_lock;
		logic [11:0] pll_ratio;
		logic [1:0]  mck_css;
		logic [2:0]  mck_prescaler_field;
		logic [1:0]  mck_master_divider_field;
		logic [1:0]  act_css;
		logic [2:0]  act_prescaler_field;
		logic [1:0]  act_master_divider_field;
		logic [1:0]  mck_timer;
		logic        mck_rdy;
		logic [2:0]  int_sts;
		logic [2:0]  int_msk;
		logic        irq;
		logic        wdt_run;
	} bcw_state_s;

	// Reset values: slow clock active, ready, watchdog running
	localparam bcw_state_s ST_RST = '{
		mck_rdy: 1'b1,
		wdt_run: 1'b1,
		act_css: CSS_SLOW,
		default: '0
	};

endpackage

// ===== rtl/bcw_top.sv
// Boot clock controller: oscillator, PLL, master clock select and watchdog enable
//
// Design decisions made here: the Wishbone slave port and the placing of the registers.

module bcw_top
	import bcw_pkg::*;
(
	// Clock and reset
	input  wire logic                clk_sys,
	input  wire logic                rstn,
	// Wishbone slave
	input  wire bcw_pkg::bcw_wb_req_s wb_req,
	output wire bcw_pkg::bcw_wb_rsp_s wb_rsp,
	// Clock controls
	output wire logic                main_osc_en,
	output wire logic [1:0]          clk_src,
	output wire logic [2:0]          clk_prescaler_field,
	output wire logic [1:0]          clk_master_divider_field,
	output wire logic [7:0]          pll_div,
	output wire logic [11:0]         pll_ratio,
	// Watchdog and interrupt
	output wire logic                wdt_running,
	output wire logic                irq
);
	import bcw_pkg::*;

	// ************************************************************
	// Helpers
	// ************************************************************

	// Byte-lane merge of write data into an old word
	function automatic logic [31:0] lane_merge(input logic [31:0] old_w,
		input logic [31:0] new_w, input logic [3:0] sel);
		logic [31:0] res;
		res = old_w;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				res[i*8 +: 8] = new_w[i*8 +: 8];
			end
		end
		return res;
	endfunction

	bcw_state_s  st_ff;
	bcw_state_s  nxt_st;
	logic        req;
	logic        wr;
	logic        wr_mor;
	logic        wr_pll;
	logic        wr_mck;
	logic        wr_wdm;
	logic [31:0] wv;
	logic [31:0] rd;
	logic [31:0] w_mor;
	logic [31:0] w_pll;
	logic [31:0] w_mck;
	logic [2:0]  ev_set;
	logic [2:0]  ev_clr;
	logic        last_div;

	// Current register images for reads and merging
	assign w_mor = {16'h0000, st_ff.osc_cnt, 7'h00, st_ff.osc_en};
	assign w_pll = {5'h00, st_ff.pll_mul, 2'h0, st_ff.pll_cnt, st_ff.pll_div};
	assign w_mck = {22'h00_0000, st_ff.mck_master_divider_field, 3'h0, st_ff.mck_prescaler_field, st_ff.mck_css};

	// Bus decode; a write takes effect on the edge that ends the ack cycle
	assign req    = wb_req.cyc & wb_req.stb;
	assign wr     = req & wb_req.we & st_ff.ack;
	assign wr_mor = wr & (wb_req.adr[7:2] == OFS_MOR[7:2]);
	assign wr_pll = wr & (wb_req.adr[7:2] == OFS_PLL[7:2]);
	assign wr_mck = wr & (wb_req.adr[7:2] == OFS_MCK[7:2]);
	assign wr_wdm = wr & (wb_req.adr[7:2] == OFS_WATCHDOG_MODE_REGISTER[7:2]);
	assign last_div = (st_ff.slow_div == 11'(SLOW_DIV_CYC - 1));

	// ************************************************************
	// Read mux, unmapped reads return zero
	// ************************************************************
	always_comb begin
		rd = 32'h0000_0000;
		case (wb_req.adr[7:2])
			OFS_MOR[7:2]:   rd = w_mor;
			OFS_PLL[7:2]:   rd = w_pll;
			OFS_MCK[7:2]:   rd = w_mck;
			OFS_STAT[7:2]:  rd = 32'({st_ff.mck_rdy, 1'b0, st_ff.pll_lock, st_ff.osc_stable});
			OFS_ISTS[7:2]:  rd = 32'(st_ff.int_sts);
			OFS_IMSK[7:2]:  rd = 32'(st_ff.int_msk);
			OFS_WATCHDOG_MODE_REGISTER[7:2]:  rd = 32'(!st_ff.wdt_run) << WD_DIS_BIT;
			OFS_RATIO[7:2]: rd = 32'({st_ff.pll_ratio, 8'h00, st_ff.pll_div});
			default:        rd = 32'h0000_0000;
		endcase
	end

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb begin
		nxt_st = st_ff;
		wv     = 32'h0000_0000;
		ev_set = 3'h0;
		ev_clr = 3'h0;
		// Single-cycle ack, dropped in the following cycle
		nxt_st.ack = req & ~st_ff.ack;
		if (req & ~st_ff.ack) begin
			nxt_st.dat = rd;
		end
		// Slow clock tick from the system clock
		nxt_st.slow_div  = last_div ? 11'h000 : st_ff.slow_div + 11'h001;
		nxt_st.slow_tick = last_div;

		// Oscillator startup countdown in slow ticks
		if (st_ff.osc_en & ~st_ff.osc_stable & st_ff.slow_tick) begin
			if (st_ff.osc_timer == 11'h000) begin
				nxt_st.osc_stable = 1'b1;
			end else begin
				nxt_st.osc_timer = st_ff.osc_timer - 11'h001;
			end
		end
		if (wr_mor) begin
			wv = lane_merge(w_mor, wb_req.dat, wb_req.sel);
			nxt_st.osc_en     = wv[MOR_EN_BIT];
			nxt_st.osc_cnt    = wv[MOR_CNT_LSB +: 8];
			nxt_st.osc_timer  = 11'(wv[MOR_CNT_LSB +: 8] * OSC_UNIT_SLOW);
			nxt_st.osc_stable = 1'b0;
		end

		// PLL lock countdown, lock only with a nonzero multiplier
		if (~st_ff.pll_lock & st_ff.slow_tick & (st_ff.pll_mul != 11'h000)) begin
			if (st_ff.pll_timer == 6'h00) begin
				nxt_st.pll_lock = 1'b1;
			end else begin
				nxt_st.pll_timer = st_ff.pll_timer - 6'h01;
			end
		end
		if (wr_pll) begin
			wv = lane_merge(w_pll, wb_req.dat, wb_req.sel);
			nxt_st.pll_div   = wv[PLL_DIV_LSB +: 8];
			nxt_st.pll_cnt   = wv[PLL_CNT_LSB +: 6];
			nxt_st.pll_mul   = wv[PLL_MUL_LSB +: 11];
			nxt_st.pll_timer = wv[PLL_CNT_LSB +: 6];
			nxt_st.pll_lock  = 1'b0;
		end
		// Ratio: divide then multiply by field plus one
		nxt_st.pll_ratio = {1'b0, nxt_st.pll_mul} + 12'h001;

		// Master clock switch delay; new setting applied when ready
		if (~st_ff.mck_rdy & st_ff.slow_tick) begin
			if (st_ff.mck_timer == 2'h0) begin
				nxt_st.mck_rdy  = 1'b1;
				nxt_st.act_css  = st_ff.mck_css;
				nxt_st.act_prescaler_field = st_ff.mck_prescaler_field;
				nxt_st.act_master_divider_field = st_ff.mck_master_divider_field;
			end else begin
				nxt_st.mck_timer = st_ff.mck_timer - 2'h1;
			end
		end
		if (wr_mck) begin
			wv = lane_merge(w_mck, wb_req.dat, wb_req.sel);
			nxt_st.mck_css   = wv[MCK_CSS_LSB +: 2];
			nxt_st.mck_prescaler_field  = wv[MCK_PRESCALER_FIELD_LSB +: 3];
			nxt_st.mck_master_divider_field  = wv[MCK_MASTER_DIVIDER_FIELD_LSB +: 2];
			nxt_st.mck_timer = 2'(MCK_SW_SLOW - 1);
			nxt_st.mck_rdy   = 1'b0;
		end

		// Watchdog stop on disable bit
		if (wr_wdm & wb_req.sel[1] & wb_req.dat[WD_DIS_BIT]) begin
			nxt_st.wdt_run = 1'b0;
		end

		// Sticky events on rising flags; set wins over clear
		ev_set = {nxt_st.mck_rdy & ~st_ff.mck_rdy, nxt_st.pll_lock & ~st_ff.pll_lock,
			nxt_st.osc_stable & ~st_ff.osc_stable};
		if (wr & (wb_req.adr[7:2] == OFS_ISTS[7:2]) & wb_req.sel[0]) begin
			ev_clr = wb_req.dat[2:0];
		end
		nxt_st.int_sts = (st_ff.int_sts & ~ev_clr) | ev_set;
		if (wr & (wb_req.adr[7:2] == OFS_IMSK[7:2]) & wb_req.sel[0]) begin
			nxt_st.int_msk = wb_req.dat[2:0];
		end
		nxt_st.irq = |(nxt_st.int_sts & nxt_st.int_msk);
	end

	// ************************************************************
	// State register, synchronous reset
	// ************************************************************
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			st_ff <= ST_RST;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// Outputs straight from flip-flops
	assign wb_rsp      = '{ack: st_ff.ack, dat: st_ff.dat};
	assign main_osc_en = st_ff.osc_en;
	assign clk_src     = st_ff.act_css;
	assign clk_prescaler_field    = st_ff.act_prescaler_field;
	assign clk_master_divider_field    = st_ff.act_master_divider_field;
	assign pll_div     = st_ff.pll_div;
	assign pll_ratio   = st_ff.pll_ratio;
	assign wdt_running = st_ff.wdt_run;
	assign irq         = st_ff.irq;

	// ************************************************************
	// Assertions
	// ************************************************************
	// Slow clock selected and watchdog running right after reset
	a_reset_slow_src: assert property (@(posedge clk_sys) disable iff (!rstn)
		$past(!rstn) |-> (clk_src == CSS_SLOW) && wdt_running)
		else $error("source not slow after reset");

	// Enable follows the write, stable flag restarts
	a_osc_start_write: assert property (@(posedge clk_sys) disable iff (!rstn)
		(wr_mor && wb_req.sel[0] && wb_req.dat[MOR_EN_BIT])
		|=> main_osc_en && !st_ff.osc_stable)
		else $error("oscillator not started by write");

	// Stable only on the tick that ends the countdown
	a_osc_stable_set: assert property (@(posedge clk_sys) disable iff (!rstn)
		$rose(st_ff.osc_stable) |-> $past(st_ff.osc_timer == 11'h000 && st_ff.slow_tick))
		else $error("stable set before interval");

	// Startup count loaded in units of eight ticks
	a_osc_unit_eight: assert property (@(posedge clk_sys) disable iff (!rstn)
		(wr_mor && wb_req.sel[1])
		|=> st_ff.osc_timer == {$past(wb_req.dat[MOR_CNT_LSB +: 8]), 3'h0})
		else $error("startup count not scaled by eight");

	// Full-word PLL write lands in the documented fields
	a_pll_field_pos: assert property (@(posedge clk_sys) disable iff (!rstn)
		(wr_pll && wb_req.sel == 4'hF) |=> pll_div == $past(wb_req.dat[PLL_DIV_LSB +: 8])
		&& st_ff.pll_mul == $past(wb_req.dat[PLL_MUL_LSB +: 11])
		&& st_ff.pll_cnt == $past(wb_req.dat[PLL_CNT_LSB +: 6]))
		else $error("pll fields misplaced");

	// Lock cleared by the write; may return only on a terminal tick
	a_pll_lock_clear: assert property (@(posedge clk_sys) disable iff (!rstn)
		wr_pll |=> !st_ff.pll_lock
		##1 (st_ff.pll_lock == $past(st_ff.slow_tick && st_ff.pll_timer == 6'h00
		&& st_ff.pll_mul != 11'h000)))
		else $error("lock not cleared on pll write");

	// Output ratio is multiplier field plus one
	a_pll_ratio_calc: assert property (@(posedge clk_sys) disable iff (!rstn)
		(wr_pll && wb_req.sel == 4'hF)
		|=> pll_ratio == {1'b0, $past(wb_req.dat[PLL_MUL_LSB +: 11])} + 12'h001)
		else $error("pll ratio not multiplier plus one");

	// Lock only after the startup countdown
	a_pll_lock_timed: assert property (@(posedge clk_sys) disable iff (!rstn)
		$rose(st_ff.pll_lock) |-> $past(st_ff.pll_timer == 6'h00 && st_ff.slow_tick))
		else $error("lock set before startup time");

	// Ready drops on a master write, old source kept
	a_mck_ready_clear: assert property (@(posedge clk_sys) disable iff (!rstn)
		wr_mck |=> !st_ff.mck_rdy && clk_src == $past(clk_src))
		else $error("ready not cleared on master write");

	// Ready returns together with the whole new setting
	a_mck_ready_apply: assert property (@(posedge clk_sys) disable iff (!rstn)
		$rose(st_ff.mck_rdy) |-> clk_src == st_ff.mck_css && clk_prescaler_field == st_ff.mck_prescaler_field
		&& clk_master_divider_field == st_ff.mck_master_divider_field)
		else $error("ready without new setting");

	// Source moves only when ready returns
	a_mck_src_hold: assert property (@(posedge clk_sys) disable iff (!rstn)
		$changed(clk_src) |-> $rose(st_ff.mck_rdy))
		else $error("source changed without ready");

	// Disable bit stops the watchdog
	a_wdt_disable_stop: assert property (@(posedge clk_sys) disable iff (!rstn)
		(wr_wdm && wb_req.sel[1] && wb_req.dat[WD_DIS_BIT]) |=> !wdt_running)
		else $error("watchdog still running after disable");

	// Only reset restarts a stopped watchdog
	a_wdt_stays_off: assert property (@(posedge clk_sys) disable iff (!rstn)
		!wdt_running |=> !wdt_running)
		else $error("watchdog restarted without reset");

	// New mask is applied to the pending events at once
	a_irq_level_out: assert property (@(posedge clk_sys) disable iff (!rstn)
		(wr && wb_req.adr[7:2] == OFS_IMSK[7:2] && wb_req.sel[0])
		|=> irq == |(st_ff.int_sts & $past(wb_req.dat[2:0])))
		else $error("irq does not follow masked status");

	// Stable event recorded even against a clear; same bit as in status
	a_event_set_wins: assert property (@(posedge clk_sys) disable iff (!rstn)
		$rose(st_ff.osc_stable) |-> st_ff.int_sts[STS_OSC_BIT])
		else $error("stable event lost");

	// Ack is a single-cycle pulse
	a_ack_one_cycle: assert property (@(posedge clk_sys) disable iff (!rstn)
		st_ff.ack |=> !st_ff.ack)
		else $error("ack longer than one cycle");

	// No stable flag while the oscillator is off
	a_osc_needs_enable: assert property (@(posedge clk_sys) disable iff (!rstn)
		!main_osc_en |-> !st_ff.osc_stable)
		else $error("stable flag without enable");

endmodule

// ===== sim/tb_bcw_top.sv
// Testbench: register, timing, interrupt and watchdog checks of the boot clock block
module tb_bcw_top;
	timeunit 1ns;
	timeprecision 1ps;
	import bcw_pkg::*;

	// ************************************************************
	// Signals and counters
	// ************************************************************
	logic        clk_sys;
	logic        rstn;
	bcw_wb_req_s wb_req;
	bcw_wb_rsp_s wb_rsp;
	logic        main_osc_en;
	logic [1:0]  clk_src;
	logic [2:0]  clk_prescaler_field;
	logic [1:0]  clk_master_divider_field;
	logic [7:0]  pll_div;
	logic [11:0] pll_ratio;
	logic        wdt_running;
	logic        irq;
	logic [31:0] q;
	int          n_mismatch = 0;
	int          compares = 0;
	int          cyc_n = 0;
	int          dt;

	// Ordinary cases: write one place, read back the same place or the ratio register
	typedef struct {logic [7:0] wa; logic [31:0] wd; logic [7:0] ra; logic [31:0] re;} bcw_row_s;
	bcw_row_s rows [4] = '{
		'{OFS_IMSK, 32'h0000_0007, OFS_IMSK, 32'h0000_0007},
		'{OFS_PLL, 32'h006D_0009, OFS_RATIO, 32'h006E_0009},
		'{OFS_PLL, 32'h0060_0009, OFS_RATIO, 32'h0061_0009},
		'{8'h20, 32'hFFFF_FFFF, 8'h20, 32'h0000_0000}
	};

	bcw_top dut (
		.clk_sys     (clk_sys),
		.rstn        (rstn),
		.wb_req      (wb_req),
		.wb_rsp      (wb_rsp),
		.main_osc_en (main_osc_en),
		.clk_src     (clk_src),
		.clk_prescaler_field    (clk_prescaler_field),
		.clk_master_divider_field    (clk_master_divider_field),
		.pll_div     (pll_div),
		.pll_ratio   (pll_ratio),
		.wdt_running (wdt_running),
		.irq         (irq)
	);

	// Clock and cycle count
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) cyc_n <= cyc_n + 1;

	// ************************************************************
	// Tasks
	// ************************************************************
	task automatic give_verdict();
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	// One classic cycle; request held until ack is sampled high
	task automatic wb_cycle(input logic we, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hF, dat: d};
		do begin
			@(posedge clk_sys);
			n++;
		end while (wb_rsp.ack !== 1'b1 && n < 20);
		q = wb_rsp.dat;
		wb_req <= '0;
		@(posedge clk_sys);
		if (n >= 20) begin
			n_mismatch++;
			give_verdict();
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		wb_cycle(1'b1, a, d);
	endtask

	task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
		wb_cycle(1'b0, a, 32'h0000_0000);
		chk(what, exp, q);
	endtask

	// Poll a status bit, bounded, and report elapsed cycles
	task automatic wait_sts(input int b);
		int t;
		t = cyc_n;
		do wb_cycle(1'b0, OFS_STAT, 32'h0000_0000);
		while (q[b] !== 1'b1 && cyc_n - t < 40000);
		dt = cyc_n - t;
		if (q[b] !== 1'b1) begin
			n_mismatch++;
			give_verdict();
		end
	endtask

	// Master clock write: ready drops, old source stays until ready returns
	task automatic mck(input logic [31:0] d);
		logic [1:0] old;
		old = clk_src;
		wr(OFS_MCK, d);
		wb_cycle(1'b0, OFS_STAT, 32'h0000_0000);
		chk("ready low", 32'h0, 32'(q[STS_MCK_BIT]));
		chk("src held", 32'(old), 32'(clk_src));
		wait_sts(STS_MCK_BIT);
		chk("ready delay", 32'h1, 32'(dt <= 3 * SLOW_DIV_CYC + 30));
		chk("mck out", 32'({d[9:8], d[4:2], d[1:0]}), 32'({clk_master_divider_field, clk_prescaler_field, clk_src}));
	endtask

	// ************************************************************
	// Main sequence
	// ************************************************************
	initial begin
		rstn = 1'b0;
		wb_req = '0;
		repeat (2) @(posedge clk_sys);
		rstn <= 1'b1;
		@(posedge clk_sys);
		chk("src reset", 32'(CSS_SLOW), 32'(clk_src));
		chk("wdt reset", 32'h1, 32'(wdt_running));
		chk("osc en reset", 32'h0, 32'(main_osc_en));
		rdc("status reset", OFS_STAT, 32'h0000_0008);
		$display("test reset done");
		foreach (rows[i]) begin
			wr(rows[i].wa, rows[i].wd);
			rdc("row", rows[i].ra, rows[i].re);
		end
		chk("pll div", 32'h9, 32'(pll_div));
		chk("pll ratio", 32'h61, 32'(pll_ratio));
		$display("test rows done");
		// Oscillator start, count 1 at bit 8
		wr(OFS_MOR, 32'h0000_0101);
		chk("osc en", 32'h1, 32'(main_osc_en));
		wait_sts(STS_OSC_BIT);
		chk("osc delay", 32'h1, 32'(dt >= 8 * SLOW_DIV_CYC && dt <= 10 * SLOW_DIV_CYC));
		$display("test oscillator done");
		// Stable and lock events pending, mask then clear
		rdc("int status", OFS_ISTS, 32'h0000_0003);
		chk("irq on", 32'h1, 32'(irq));
		wr(OFS_IMSK, 32'h0000_0000);
		chk("irq masked", 32'h0, 32'(irq));
		wr(OFS_IMSK, 32'h0000_0007);
		chk("irq again", 32'h1, 32'(irq));
		wr(OFS_ISTS, 32'h0000_0007);
		rdc("int cleared", OFS_ISTS, 32'h0000_0000);
		chk("irq off", 32'h0, 32'(irq));
		$display("test interrupt done");
		// Move to the main oscillator before the PLL
		mck(32'h0000_0001);
		wr(OFS_PLL, 32'h006D_0109);
		wb_cycle(1'b0, OFS_STAT, 32'h0000_0000);
		chk("lock low", 32'h0, 32'(q[STS_LOCK_BIT]));
		wait_sts(STS_LOCK_BIT);
		chk("lock delay", 32'h1, 32'(dt <= 3 * SLOW_DIV_CYC + 30));
		chk("pll div 2", 32'h9, 32'(pll_div));
		chk("pll ratio 2", 32'h6E, 32'(pll_ratio));
		$display("test pll done");
		// Prescaler first, then the PLL as source
		mck(32'h0000_0105);
		mck(32'h0000_0106);
		rdc("int events", OFS_ISTS, 32'h0000_0006);
		$display("test master clock done");
		wr(OFS_WATCHDOG_MODE_REGISTER, 32'h0000_8000);
		chk("wdt stop", 32'h0, 32'(wdt_running));
		rdc("wdt mode", OFS_WATCHDOG_MODE_REGISTER, 32'h0000_8000);
		rstn <= 1'b0;
		repeat (2) @(posedge clk_sys);
		rstn <= 1'b1;
		@(posedge clk_sys);
		chk("wdt rerun", 32'h1, 32'(wdt_running));
		chk("src rerun", 32'(CSS_SLOW), 32'(clk_src));
		$display("test watchdog done");
		give_verdict();
	end
endmodule
